/* shared/rtc_params.svh */
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// Register byte addresses on the plain register port.
`define ADDR_CFG_ONE 4'h0
`define ADDR_CAL 4'h1
`define ADDR_CFG_TWO 4'h2
`define ADDR_ALM_CFG 4'h3
`define ADDR_ALM_RPT 4'h4
`define ADDR_TIME_LO 4'h5
`define ADDR_TIME_HI 4'h6
`define ADDR_ALM_LO 4'h7
`define ADDR_ALM_HI 4'h8
`define ADDR_UNLOCK 4'h9
// Unlock keys, written in this order to the unlock address.
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa
// Field positions.
`define B_ENABLE 7
`define B_WREN 5
`define B_SYNC 4
`define B_HALF 3
`define B_OE 2
`define B_PWC_EN 7
`define B_PWC_POL 6
`define B_ALM_EN 7
`define B_CHIME 6
// Reset values.
`define RST_BYTE 8'h00
// Source ticks per second for each timing source.
`define TICKS_XTAL 16'd32768
`define TICKS_OSC 16'd31000
`define TICKS_50HZ 16'd50
`define TICKS_60HZ 16'd60
// Calibration pulses per count.
`define CAL_STEP 4
`endif

/* shared/rtc_pkg.sv */
package rtc_pkg;
  // Timing source choices.
  typedef enum logic [1:0] {
    SRC_XTAL = 2'b00,
    SRC_OSC = 2'b01,
    SRC_50HZ = 2'b10,
    SRC_60HZ = 2'b11
  } src_sel_t;
  // Pin output choices.
  typedef enum logic [1:0] {
    PIN_ALARM = 2'b00,
    PIN_SECONDS = 2'b01,
    PIN_SOURCE = 2'b10,
    PIN_POWER = 2'b11
  } pin_sel_t;
  // Unlock sequence states.
  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_OPEN = 3'b100
  } unlock_st_t;
  // Calendar held in BCD.
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] month;
    logic [7:0] year;
  } cal_t;
  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

/* sim/rtc_calendar_control_alarm_tb.sv */
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_calendar_control_alarm_tb;
  import rtc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic src_tick = 1'b0;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic clk_pin, power_pin, stab_clk, sample_clk, alarm_event, alarm_flag;
  logic stab_q = 1'b0, samp_q = 1'b0, pin_q = 1'b0;
  int errors = 0, samples_checked = 0, ev_cnt = 0, stab_cnt = 0, samp_cnt = 0, pin_cnt = 0;
  int e0, p0, s0, q0;
  logic [7:0] tv [8] = '{8'h24, 8'h00, 8'h29, 8'h02, 8'h23, 8'h05, 8'h58, 8'h59};
  logic [7:0] av [8] = '{8'h00, 8'h00, 8'h15, 8'h06, 8'h07, 8'h03, 8'h00, 8'h30};

  // ----------------------------------------
  // Clock, design and monitors
  // ----------------------------------------
  always #4 ref_clk = ~ref_clk;

  rtc_calendar_control_alarm #(.CNT_W(16)) dut (.ref_clk(ref_clk), .rst(rst), .por(por), .req(req), .rdata(rdata),
    .src_tick(src_tick), .clk_pin(clk_pin), .power_pin(power_pin), .stab_clk(stab_clk), .sample_clk(sample_clk),
    .alarm_event(alarm_event), .alarm_flag(alarm_flag));

  // Counts rising edges of the derived clocks and the alarm pulses.
  always @(posedge ref_clk) begin
    {stab_q, samp_q, pin_q} <= {stab_clk, sample_clk, clk_pin};
    if (stab_clk === 1'b1 && stab_q !== 1'b1) stab_cnt++;
    if (sample_clk === 1'b1 && samp_q !== 1'b1) samp_cnt++;
    if (clk_pin === 1'b1 && pin_q !== 1'b1) pin_cnt++;
    if (alarm_event === 1'b1) ev_cnt++;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A write strobe for one cycle, then one idle cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req <= '0;
    @(posedge ref_clk);
  endtask

  // A read strobe; the data stand in the following cycle only.
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    logic [7:0] v;
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1 v = rdata;
    @(posedge ref_clk);
    check(v & m, e);
  endtask

  // Source pulses, each one cycle high and three low.
  task automatic ticks(input int n);
    repeat (n) begin
      src_tick <= 1'b1;
      @(posedge ref_clk);
      src_tick <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // Walks a value window from pointer 3 down, low byte then high byte.
  task automatic win_fill(input logic [3:0] ca, input logic [7:0] cv, input logic [3:0] lo, input logic [7:0] d [8]);
    wr(ca, cv | 8'h03);
    for (int i = 0; i < 8; i++) wr(lo + 4'(i % 2), d[i]);
  endtask

  task automatic win_check(input logic [3:0] ca, input logic [7:0] cv, input logic [3:0] lo, input logic [7:0] d [8]);
    wr(ca, cv | 8'h03);
    for (int i = 0; i < 8; i++) rd(lo + 4'(i % 2), d[i]);
    rd(lo + 4'h1, d[7]);
  endtask

  task automatic wrap_up();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 5; a++) rd(4'(a), `RST_BYTE);
    rd(4'hb, 8'h00);
    check({7'h0, power_pin}, 8'h01);
    wr(`ADDR_CFG_TWO, 8'hff);
    wr(`ADDR_CFG_ONE, 8'ha0);
    rd(`ADDR_CFG_TWO, 8'h00);
    rd(`ADDR_CFG_ONE, 8'h00);
    wr(`ADDR_UNLOCK, `UNLOCK_KEY1);
    wr(`ADDR_CAL, 8'h7f);
    wr(`ADDR_UNLOCK, `UNLOCK_KEY2);
    wr(`ADDR_CFG_ONE, 8'h20);
    rd(`ADDR_CFG_ONE, 8'h00);
    wr(`ADDR_UNLOCK, `UNLOCK_KEY1);
    wr(`ADDR_UNLOCK, `UNLOCK_KEY2);
    wr(`ADDR_CFG_ONE, 8'h20);
    rd(`ADDR_CFG_ONE, 8'h20);
    rd(`ADDR_CAL, 8'h7f);
    wr(`ADDR_CFG_ONE, 8'h80);
    rd(`ADDR_CFG_ONE, 8'ha0);
    wr(`ADDR_CAL, 8'h80);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`ADDR_CAL, 8'h80);
    rd(`ADDR_CFG_ONE, 8'ha0);
    wr(`ADDR_CAL, 8'h00);
    // Every encoding of power control, timing source and pin select.
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CFG_TWO, 8'((i << 6) | (i << 2) | i));
      rd(`ADDR_CFG_TWO, 8'((i << 6) | (i << 2) | i));
      check({7'h0, power_pin}, {7'h0, i[1] ? i[0] : !i[0]});
    end
    wr(`ADDR_CFG_ONE, 8'ha4);
    wr(`ADDR_CFG_TWO, 8'hc3);
    @(posedge ref_clk);
    check({7'h0, clk_pin}, 8'h01);
    // Source clock on the pin, one prescaler at a time.
    for (int j = 0; j < 2; j++) begin
      wr(`ADDR_CFG_TWO, j ? 8'h12 : 8'h22);
      {p0, s0, q0} = {pin_cnt, stab_cnt, samp_cnt};
      ticks(8);
      check(8'(pin_cnt - p0), 8'h08);
      check(8'(stab_cnt - s0), j ? 8'h08 : 8'h04);
      check(8'(samp_cnt - q0), j ? 8'h04 : 8'h08);
    end
    wr(`ADDR_CFG_ONE, 8'ha0);
    p0 = pin_cnt;
    ticks(4);
    check(8'(pin_cnt - p0), 8'h00);
    win_fill(`ADDR_CFG_ONE, 8'ha0, `ADDR_TIME_LO, tv);
    win_check(`ADDR_CFG_ONE, 8'ha0, `ADDR_TIME_LO, tv);
    win_fill(`ADDR_ALM_CFG, 8'h00, `ADDR_ALM_LO, av);
    win_check(`ADDR_ALM_CFG, 8'h00, `ADDR_ALM_LO, av);
    // Half-second status on 50 Hz mains.
    wr(`ADDR_CFG_TWO, 8'h08);
    wr(`ADDR_TIME_LO, 8'h00);
    rd(`ADDR_CFG_ONE, 8'h00, 8'h18);
    ticks(30);
    rd(`ADDR_CFG_ONE, 8'h18, 8'h18);
    ticks(25);
    rd(`ADDR_CFG_ONE, 8'h00, 8'h18);
    rd(`ADDR_TIME_LO, 8'h01);
    // One repeat, no chime: two events, then the alarm switches off.
    wr(`ADDR_CFG_ONE, 8'ha4);
    wr(`ADDR_ALM_RPT, 8'h01);
    wr(`ADDR_ALM_CFG, 8'h80);
    wr(`ADDR_TIME_LO, 8'h00);
    {e0, p0} = {ev_cnt, pin_cnt};
    ticks(155);
    check(8'(ev_cnt - e0), 8'h02);
    check(8'(pin_cnt - p0), 8'h02);
    rd(`ADDR_ALM_CFG, 8'h00, 8'h80);
    rd(`ADDR_ALM_RPT, 8'h00);
    check({7'h0, alarm_flag}, 8'h01);
    // Chime lets the counter wrap and keeps the alarm on.
    wr(`ADDR_ALM_CFG, 8'hc0);
    wr(`ADDR_TIME_LO, 8'h00);
    ticks(30);
    rd(`ADDR_ALM_RPT, 8'hff);
    rd(`ADDR_ALM_CFG, 8'hc0);
    // Drift calibration on 60 Hz mains: each count shifts the first half second by four pulses.
    wr(`ADDR_CFG_TWO, 8'h0c);
    for (int k = 0; k < 2; k++) begin
      wr(`ADDR_CAL, k ? 8'hff : 8'h01);
      wr(`ADDR_TIME_LO, 8'h59);
      ticks(k ? 93 : 85);
      rd(`ADDR_CFG_ONE, 8'h00, 8'h08);
      ticks(1);
      rd(`ADDR_CFG_ONE, 8'h08, 8'h08);
    end
    wrap_up();
  end

  // Cuts a hang short; the sequence needs well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule

/* sim/rtc_ctl_checker_sva.sv */
`timescale 1ns/10ps
`include "rtc_params.svh"
// ----------------------------------------
// Port checker with register shadows
// ----------------------------------------
module rtc_ctl_checker
  import rtc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  input wire rtc_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic clk_pin,
  input wire logic power_pin,
  input wire logic alarm_event,
  input wire logic alarm_flag
);
  logic [1:0] key_ff;
  logic wren_ff, en_ff, oe_ff;
  logic [7:0] cal_ff, cfg2_ff;
  wire wr0 = req.wr && req.addr == `ADDR_CFG_ONE;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || por);
  // Tracks progress through the two unlock keys.
  always_ff @(posedge ref_clk or posedge rst or posedge por) begin
    if (rst || por) begin
      key_ff <= 2'h0;
    end else if (req.wr) begin
      if (req.addr == `ADDR_UNLOCK && req.wdata == `UNLOCK_KEY1) key_ff <= 2'h1;
      else if (key_ff == 2'h1 && req.addr == `ADDR_UNLOCK && req.wdata == `UNLOCK_KEY2) key_ff <= 2'h2;
      else key_ff <= 2'h0;
    end
  end
  // Mirrors the configuration bits; only power-on clears them.
  always_ff @(posedge ref_clk or posedge por) begin
    if (por) begin
      {wren_ff, en_ff, oe_ff, cal_ff, cfg2_ff} <= '0;
    end else if (req.wr) begin
      if (req.addr == `ADDR_CAL) cal_ff <= req.wdata;
      if (req.addr == `ADDR_CFG_TWO && wren_ff) cfg2_ff <= req.wdata;
      if (wr0 && key_ff == 2'h2) wren_ff <= req.wdata[`B_WREN];
      if (wr0 && wren_ff) en_ff <= req.wdata[`B_ENABLE];
      if (wr0) oe_ff <= req.wdata[`B_OE];
    end
  end
  property p_cal_back;
    req.rd && req.addr == `ADDR_CAL |=> rdata == $past(cal_ff);
  endproperty
  a_cal_back: assert property (p_cal_back) else $error("calibration readback differs");
  property p_cfg2_back;
    req.rd && req.addr == `ADDR_CFG_TWO |=> rdata == $past(cfg2_ff);
  endproperty
  a_cfg2_back: assert property (p_cfg2_back) else $error("config two readback differs");
  property p_enable_lock;
    req.rd && req.addr == `ADDR_CFG_ONE |=> rdata[`B_ENABLE] == $past(en_ff) && !rdata[6];
  endproperty
  a_enable_lock: assert property (p_enable_lock) else $error("enable bit differs");
  property p_unlock_key;
    req.rd && req.addr == `ADDR_CFG_ONE |=> rdata[`B_WREN] == $past(wren_ff);
  endproperty
  a_unlock_key: assert property (p_unlock_key) else $error("write unlock bit differs");
  property p_pin_off;
    !oe_ff && !$past(oe_ff) |-> !clk_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("clock pin active while disabled");
  property p_power_level;
    cfg2_ff == $past(cfg2_ff) && cfg2_ff == $past(cfg2_ff, 2)
      |-> power_pin == (cfg2_ff[`B_PWC_EN] ? cfg2_ff[`B_PWC_POL] : !cfg2_ff[`B_PWC_POL]);
  endproperty
  a_power_level: assert property (p_power_level) else $error("power pin level wrong");
  property p_event_single;
    alarm_event |=> !alarm_event;
  endproperty
  a_event_single: assert property (p_event_single) else $error("alarm event longer than one cycle");
  property p_flag_set;
    alarm_event |-> ##[0:1] alarm_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm flag not set");
  property p_flag_sticky;
    alarm_flag |=> alarm_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("alarm flag dropped");
  // Main scenarios reached.
  c_event: cover property (alarm_event);
  c_power: cover property (power_pin && cfg2_ff[`B_PWC_EN]);
  c_pin: cover property (clk_pin && oe_ff);
endmodule

bind rtc_calendar_control_alarm rtc_ctl_checker #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .rst(rst), .por(por),
  .req(req), .rdata(rdata), .clk_pin(clk_pin), .power_pin(power_pin), .alarm_event(alarm_event),
  .alarm_flag(alarm_flag));

/* src/rtc_calendar_control_alarm.sv */
`timescale 1ns/10ps
`include "rtc_params.svh"
//
// Function
// - Enable bit runs the calendar; writing it needs the write unlock set.
// - Time window and config two writes are ignored unless unlocked.
// - The write unlock bit changes only through the unlock key sequence.
// - Ripple flag is high around rollover; software reads twice when it is high.
// - Half-second flag shows second half; low seconds write clears it.
// - Clock pin carries the selected signal only when output enable is set.
// - Time pointer selects minutes/weekday/month high, seconds/hours/day/year low.
// - High time window access decrements the time pointer, stopping at zero.
// - Configuration registers reset only on power-on reset.
// - Signed calibration adds or removes four pulses per minute per count.
// - Power output active only when enabled, polarity bit sets level.
// - Stability and sample clocks divide source by two when prescaler set and calendar enabled.
// - Source select picks crystal, oscillator, 50 Hz or 60 Hz.
// - Pin select routes alarm, seconds, source clock or power signal.
// - Alarm enable self-clears after event when count zero and chime off.
// - Chime lets repeat count wrap zero to FFh; otherwise it stops.
// - Alarm mask chooses interval from half second up to yearly.
// - Yearly alarm on February 29 matches only leap years.
// - Alarm pointer selects alarm minutes/weekday/month high, seconds/hours/day low.
// - High alarm window access decrements the alarm pointer, stopping at zero.
// - Repeat counter decrements on each alarm event, except at zero with chime off.
// - Time values kept in BCD with documented digit ranges.
module rtc_calendar_control_alarm #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  input wire rtc_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic src_tick,
  output logic clk_pin,
  output logic power_pin,
  output logic stab_clk,
  output logic sample_clk,
  output logic alarm_event,
  output logic alarm_flag
);
  import rtc_pkg::*;

  // Refuses a divider too narrow to count the fastest source.
  if (CNT_W < 16) begin
    $error("CNT_W too small for source counts");
  end

  // --------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------
  // BCD increment with wrap to a low value above a high limit.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] r;
    r = v;
    if (v == hi) begin
      r = lo;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    // Year 2000..2099: leap when BCD value divisible by four.
    return ((y[4] == 1'b0) && (y[1:0] == 2'b00)) ||
           ((y[4] == 1'b1) && (y[1:0] == 2'b10));
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] d;
    d = 8'h31;
    if (m == 8'h02) begin
      d = is_leap(y) ? 8'h29 : 8'h28;
    end else if ((m == 8'h04) || (m == 8'h06) || (m == 8'h09) || (m == 8'h11)) begin
      d = 8'h30;
    end
    return d;
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic [7:0] cfg1_ff, nxt_cfg1;
  logic [7:0] cal_ff, nxt_cal;
  logic [7:0] cfg2_ff, nxt_cfg2;
  logic [7:0] acfg_ff, nxt_acfg;
  logic [7:0] rpt_ff, nxt_rpt;
  cal_t tm_ff, nxt_tm;
  cal_t al_ff, nxt_al;
  unlock_st_t ul_ff, nxt_ul;
  logic [CNT_W-1:0] div_ff, nxt_div;
  logic [5:0] sec_ff, nxt_sec;
  logic [9:0] adj_ff, nxt_adj;
  logic [7:0] rdata_ff, nxt_rdata;
  logic ev_ff, nxt_ev;
  logic aflag_ff, nxt_aflag;
  logic pdiv_ff, nxt_pdiv;
  logic pin_ff, nxt_pin;
  logic [CNT_W-1:0] half_cnt;
  logic half_tick;
  logic sec_tick;
  logic match;
  logic bump;
  logic wr_ok;

  // Half-period count for the selected source.
  always_comb begin
    unique case (src_sel_t'(cfg2_ff[3:2]))
      SRC_XTAL: half_cnt = CNT_W'(`TICKS_XTAL / 2);
      SRC_OSC: half_cnt = CNT_W'(`TICKS_OSC / 2);
      SRC_50HZ: half_cnt = CNT_W'(`TICKS_50HZ / 2);
      SRC_60HZ: half_cnt = CNT_W'(`TICKS_60HZ / 2);
    endcase
  end

  assign wr_ok = cfg1_ff[`B_WREN];
  assign half_tick = cfg1_ff[`B_ENABLE] && src_tick && (div_ff >= half_cnt - CNT_W'(1)) && !bump;
  assign sec_tick = half_tick && cfg1_ff[`B_HALF];

  // --------------------------------------------------------------
  // Alarm match
  // --------------------------------------------------------------
  // Fields compared grow with the mask, except weekday, compared at seven only; zero compares nothing at all.
  always_comb begin
    logic [3:0] m;
    m = acfg_ff[5:2];
    match = 1'b1;
    if (m >= 4'h2 && tm_ff.sec[3:0] != al_ff.sec[3:0]) match = 1'b0;
    if (m >= 4'h3 && tm_ff.sec[7:4] != al_ff.sec[7:4]) match = 1'b0;
    if (m >= 4'h4 && tm_ff.min[3:0] != al_ff.min[3:0]) match = 1'b0;
    if (m >= 4'h5 && tm_ff.min[7:4] != al_ff.min[7:4]) match = 1'b0;
    if (m >= 4'h6 && m != 4'h8 && m != 4'h9 && tm_ff.hour != al_ff.hour) match = 1'b0;
    if (m >= 4'h8 && tm_ff.hour != al_ff.hour) match = 1'b0;
    if (m == 4'h7 && tm_ff.wday != al_ff.wday) match = 1'b0;
    if (m >= 4'h8 && tm_ff.day != al_ff.day) match = 1'b0;
    if (m == 4'h9 && tm_ff.month != al_ff.month) match = 1'b0;
    if (m == 4'h9 && al_ff.month == 8'h02 && al_ff.day == 8'h29 && !is_leap(tm_ff.year)) match = 1'b0;
    if (m >= 4'ha) match = 1'b0;
    if (m == 4'h0) begin
      match = half_tick;
    end else begin
      match = match && sec_tick && (tm_ff.sec[0] == 1'b0 || m == 4'h1 || m >= 4'h2);
    end
  end

  // --------------------------------------------------------------
  // Registers and calendar next state
  // --------------------------------------------------------------
  always_comb begin
    logic alarm_now;
    logic hi_acc;
    logic ahi_acc;
    logic [1:0] tp;
    logic [1:0] ap;
    nxt_cfg1 = cfg1_ff;
    nxt_cal = cal_ff;
    nxt_cfg2 = cfg2_ff;
    nxt_acfg = acfg_ff;
    nxt_rpt = rpt_ff;
    nxt_tm = tm_ff;
    nxt_al = al_ff;
    nxt_ul = ul_ff;
    nxt_div = div_ff;
    nxt_sec = sec_ff;
    nxt_adj = adj_ff;
    nxt_rdata = 8'h00;
    nxt_pdiv = pdiv_ff;
    bump = 1'b0;
    tp = cfg1_ff[1:0];
    ap = acfg_ff[1:0];
    hi_acc = (req.wr || req.rd) && req.addr == `ADDR_TIME_HI;
    ahi_acc = (req.wr || req.rd) && req.addr == `ADDR_ALM_HI;
    alarm_now = acfg_ff[`B_ALM_EN] && match;
    // Drift calibration: once a minute pulses are skipped or added.
    if (src_tick && cfg1_ff[`B_ENABLE]) begin
      nxt_pdiv = !pdiv_ff;
      if (adj_ff != 10'd0) begin
        nxt_adj = adj_ff - 10'd1;
        bump = cal_ff[7];
        nxt_div = cal_ff[7] ? div_ff : div_ff + CNT_W'(2);
      end else begin
        nxt_div = div_ff + CNT_W'(1);
      end
    end
    if (half_tick) begin
      nxt_div = '0;
      nxt_cfg1[`B_HALF] = !cfg1_ff[`B_HALF];
    end
    // Seconds tick advances the BCD calendar.
    if (sec_tick) begin
      nxt_tm.sec = bcd_inc(tm_ff.sec, 8'h59, 8'h00);
      if (tm_ff.sec == 8'h59) begin
        nxt_sec = (sec_ff == 6'd59) ? 6'd0 : sec_ff + 6'd1;
        nxt_tm.min = bcd_inc(tm_ff.min, 8'h59, 8'h00);
        if (tm_ff.min == 8'h59) begin
          nxt_tm.hour = bcd_inc(tm_ff.hour, 8'h23, 8'h00);
          if (tm_ff.hour == 8'h23) begin
            nxt_tm.wday = (tm_ff.wday == 8'h06) ? 8'h00 : tm_ff.wday + 8'h01;
            nxt_tm.day = bcd_inc(tm_ff.day, last_day(tm_ff.month, tm_ff.year), 8'h01);
            if (tm_ff.day == last_day(tm_ff.month, tm_ff.year)) begin
              nxt_tm.month = bcd_inc(tm_ff.month, 8'h12, 8'h01);
              if (tm_ff.month == 8'h12) begin
                nxt_tm.year = bcd_inc(tm_ff.year, 8'h99, 8'h00);
              end
            end
          end
        end
        // Each minute reloads the calibration pulse budget.
        nxt_adj = cal_ff[7] ? 10'(($unsigned(~cal_ff) + 10'd1) * `CAL_STEP) : 10'(cal_ff * `CAL_STEP);
      end
    end
    // Ripple flag: set across the last half second before a seconds rollover.
    nxt_cfg1[`B_SYNC] = cfg1_ff[`B_ENABLE] && cfg1_ff[`B_HALF];
    // Alarm event handling.
    if (alarm_now) begin
      if (rpt_ff != 8'h00 || acfg_ff[`B_CHIME]) begin
        nxt_rpt = rpt_ff - 8'h01;
      end else begin
        nxt_acfg[`B_ALM_EN] = 1'b0;
      end
    end
    // Unlock sequence.
    if (req.wr && req.addr == `ADDR_UNLOCK) begin
      nxt_ul = UL_IDLE;
      if (req.wdata == `UNLOCK_KEY1) begin
        nxt_ul = UL_KEY1;
      end else if (ul_ff == UL_KEY1 && req.wdata == `UNLOCK_KEY2) begin
        nxt_ul = UL_OPEN;
      end
    end else if (req.wr) begin
      nxt_ul = UL_IDLE;
    end
    // Software writes.
    if (req.wr) begin
      unique case (req.addr)
        `ADDR_CFG_ONE: begin
          nxt_cfg1[2:0] = req.wdata[2:0];
          if (wr_ok) nxt_cfg1[`B_ENABLE] = req.wdata[`B_ENABLE];
          if (ul_ff == UL_OPEN) nxt_cfg1[`B_WREN] = req.wdata[`B_WREN];
          tp = req.wdata[1:0];
        end
        `ADDR_CAL: nxt_cal = req.wdata;
        `ADDR_CFG_TWO: if (wr_ok) nxt_cfg2 = req.wdata;
        `ADDR_ALM_CFG: begin
          nxt_acfg = req.wdata;
          ap = req.wdata[1:0];
        end
        `ADDR_ALM_RPT: nxt_rpt = req.wdata;
        `ADDR_TIME_LO: if (wr_ok) begin
          unique case (tp)
            2'b00: begin
              nxt_tm.sec = {1'b0, req.wdata[6:0]};
              nxt_cfg1[`B_HALF] = 1'b0;
              nxt_div = '0;
            end
            2'b01: nxt_tm.hour = {2'b00, req.wdata[5:0]};
            2'b10: nxt_tm.day = {2'b00, req.wdata[5:0]};
            2'b11: nxt_tm.year = req.wdata;
          endcase
        end
        `ADDR_TIME_HI: if (wr_ok) begin
          unique case (tp)
            2'b00: nxt_tm.min = {1'b0, req.wdata[6:0]};
            2'b01: nxt_tm.wday = {5'h00, req.wdata[2:0]};
            2'b10: nxt_tm.month = {3'h0, req.wdata[4:0]};
            2'b11: nxt_tm.month = tm_ff.month;
          endcase
        end
        `ADDR_ALM_LO: begin
          unique case (ap)
            2'b00: nxt_al.sec = {1'b0, req.wdata[6:0]};
            2'b01: nxt_al.hour = {2'b00, req.wdata[5:0]};
            2'b10: nxt_al.day = {2'b00, req.wdata[5:0]};
            2'b11: nxt_al.day = al_ff.day;
          endcase
        end
        `ADDR_ALM_HI: begin
          unique case (ap)
            2'b00: nxt_al.min = {1'b0, req.wdata[6:0]};
            2'b01: nxt_al.wday = {5'h00, req.wdata[2:0]};
            2'b10: nxt_al.month = {3'h0, req.wdata[4:0]};
            2'b11: nxt_al.month = al_ff.month;
          endcase
        end
        default: nxt_ul = nxt_ul;
      endcase
    end
    // Reads.
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_CFG_ONE: nxt_rdata = {cfg1_ff[7], 1'b0, cfg1_ff[5:0]};
        `ADDR_CAL: nxt_rdata = cal_ff;
        `ADDR_CFG_TWO: nxt_rdata = cfg2_ff;
        `ADDR_ALM_CFG: nxt_rdata = acfg_ff;
        `ADDR_ALM_RPT: nxt_rdata = rpt_ff;
        `ADDR_TIME_LO: nxt_rdata = (tp == 2'b00) ? tm_ff.sec : (tp == 2'b01) ? tm_ff.hour :
                                   (tp == 2'b10) ? tm_ff.day : tm_ff.year;
        `ADDR_TIME_HI: nxt_rdata = (tp == 2'b00) ? tm_ff.min : (tp == 2'b01) ? tm_ff.wday :
                                   (tp == 2'b10) ? tm_ff.month : 8'h00;
        `ADDR_ALM_LO: nxt_rdata = (ap == 2'b00) ? al_ff.sec : (ap == 2'b01) ? al_ff.hour :
                                  (ap == 2'b10) ? al_ff.day : 8'h00;
        `ADDR_ALM_HI: nxt_rdata = (ap == 2'b00) ? al_ff.min : (ap == 2'b01) ? al_ff.wday :
                                  (ap == 2'b10) ? al_ff.month : 8'h00;
        default: nxt_rdata = 8'h00;
      endcase
    end
    // Pointer auto-decrement on high window access.
    if (hi_acc && tp != 2'b00) nxt_cfg1[1:0] = tp - 2'b01;
    if (ahi_acc && ap != 2'b00) nxt_acfg[1:0] = ap - 2'b01;
    nxt_ev = alarm_now;
    nxt_aflag = alarm_now || aflag_ff;
  end

  // Output pin selection and power control level.
  always_comb begin
    logic pwr;
    pwr = cfg2_ff[`B_PWC_EN] ? cfg2_ff[`B_PWC_POL] : !cfg2_ff[`B_PWC_POL];
    nxt_pin = 1'b0;
    if (cfg1_ff[`B_OE]) begin
      unique case (pin_sel_t'(cfg2_ff[1:0]))
        PIN_ALARM: nxt_pin = ev_ff;
        PIN_SECONDS: nxt_pin = cfg1_ff[`B_HALF];
        PIN_SOURCE: nxt_pin = src_tick;
        PIN_POWER: nxt_pin = pwr;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Flip-flops
  // --------------------------------------------------------------
  // Configuration state clears only on power-on reset.
  always_ff @(posedge ref_clk or posedge por) begin
    if (por) begin
      cfg1_ff <= `RST_BYTE;
      cfg2_ff <= `RST_BYTE;
      cal_ff <= `RST_BYTE;
      acfg_ff <= `RST_BYTE;
      rpt_ff <= `RST_BYTE;
      tm_ff <= '0;
      al_ff <= '0;
      div_ff <= '0;
      sec_ff <= '0;
      adj_ff <= '0;
      pdiv_ff <= 1'b0;
    end else begin
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= nxt_cfg2;
      cal_ff <= nxt_cal;
      acfg_ff <= nxt_acfg;
      rpt_ff <= nxt_rpt;
      tm_ff <= nxt_tm;
      al_ff <= nxt_al;
      div_ff <= nxt_div;
      sec_ff <= nxt_sec;
      adj_ff <= nxt_adj;
      pdiv_ff <= nxt_pdiv;
    end
  end

  // Bus and event state clears on the ordinary reset only; power-on reset does not clear it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ul_ff <= UL_IDLE;
      rdata_ff <= 8'h00;
      ev_ff <= 1'b0;
      aflag_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      ul_ff <= nxt_ul;
      rdata_ff <= nxt_rdata;
      ev_ff <= nxt_ev;
      aflag_ff <= nxt_aflag;
      pin_ff <= nxt_pin;
    end
  end

  assign rdata = rdata_ff;
  assign alarm_event = ev_ff;
  assign alarm_flag = aflag_ff;
  assign clk_pin = pin_ff;
  assign power_pin = cfg2_ff[`B_PWC_EN] ? cfg2_ff[`B_PWC_POL] : !cfg2_ff[`B_PWC_POL];
  assign stab_clk = cfg2_ff[5] ? pdiv_ff : src_tick;
  assign sample_clk = cfg2_ff[4] ? pdiv_ff : src_tick;
endmodule
